// file: verilog/qpfes_sequencer.sv
// Top of the four-phase fetch/execute sequencer with two-stage pipeline.
// Notes on behaviour
// - Input clock divided by four into phases.
// - Pointer increments in phase one each cycle.
// - Fetched word captured at phase four.
// - Instruction register loads phase one, executes after.
// - Data read phase two, write phase four.
// - Fetch overlaps execute, one per cycle.
// - Pointer-changing instructions take two cycles.
// - RC mode drives quarter-rate cycle pin.
// - Low master clear resets sequencer and core.
// - Flushed fetch executes as no-operation.
// - Thirteen-bit pointer wraps within implemented space.
// - Reset fetches zero, interrupt fetches four.
`timescale 1ns/100ps
module qpfes_sequencer
   import qpfes_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic master_clear_n,
   input wire logic osc_mode_rc,
   input wire logic [12:0] impl_mask,
   input wire logic [13:0] prog_rdata,
   input wire logic branch_req,
   input wire logic [12:0] branch_target,
   input wire logic irq_req,
   output logic [12:0] instruction_pointer,
   output logic [12:0] prog_addr,
   output logic [13:0] instruction_register,
   output logic exec_valid,
   output logic data_rd_en,
   output logic data_wr_en,
   output logic exec_done,
   output logic irq_ack,
   output logic phase_one,
   output logic phase_two,
   output logic phase_three,
   output logic phase_four,
   output logic cycle_rate_output_pin
);
   // ---------------------------------------------------------------
   // Local reset
   // ---------------------------------------------------------------
   // Master clear and system reset both clear everything; master clear is
   // taken synchronously here, but the phase generator takes it asynchronously with resetn.
   logic core_clear;
   assign core_clear = !master_clear_n;

   function automatic logic [12:0] wrap_ptr(input logic [12:0] p, input logic [12:0] m);
      wrap_ptr = p & m;
   endfunction : wrap_ptr

   logic [12:0] ptr_r;
   logic [12:0] ptr_nxt;
   logic [13:0] fetch_r;
   logic fetch_valid_r;
   logic [13:0] ir_r;
   logic exec_valid_r;
   logic irq_ack_r;
   logic done_r;
   logic rd_r;
   logic wr_r;
   logic [12:0] addr_r;
   logic ph_one;
   logic ph_two;
   logic ph_four;
   logic redirect_now;

   // Master clear resets the phase counter at once, so the phases restart at
   // phase one in step with the synchronous clear of the pipeline registers.
   qpfes_phase_gen u_phase (
      .sys_clk(sys_clk),
      .resetn(resetn && master_clear_n),
      .osc_mode_rc(osc_mode_rc),
      .phase_one(ph_one),
      .phase_two(ph_two),
      .phase_three(phase_three),
      .phase_four(ph_four),
      .cycle_rate_output_pin(cycle_rate_output_pin)
   );

   // ---------------------------------------------------------------
   // Pipeline timing
   // ---------------------------------------------------------------
   // One instruction cycle is four clocks, seen here from one instruction.
   // In cycle N, phase one steps the pointer and presents the fetch address.
   // At the end of phase four of cycle N the program word is captured.
   // Phase one of cycle N+1 loads it into the instruction register.
   // Phase two of cycle N+1 carries the operand read strobe.
   // Phase four of cycle N+1 carries the result write strobe.
   // Phase one of cycle N+2 reports the instruction as done.
   // The next word is fetched while N+1 executes, so only a pointer change
   // costs a cycle, because the word fetched behind it is dropped.

   // A redirect is decided at the end of execution (phase four) by either a
   // branch from the executing instruction or an interrupt entry.
   assign redirect_now = ph_four && ((exec_valid_r && branch_req) || irq_req);

   // ---------------------------------------------------------------
   // Instruction pointer
   // ---------------------------------------------------------------
   always_comb begin
      ptr_nxt = ptr_r;
      if (redirect_now) begin
         ptr_nxt = irq_req ? QPFES_IRQ_VECTOR : wrap_ptr(branch_target, impl_mask);
      end else if (ph_one) begin
         // After a redirect this steps past the target that is being fetched.
         ptr_nxt = wrap_ptr(ptr_r + QPFES_PTR_STEP, impl_mask);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ptr_r <= QPFES_RESET_VECTOR;
      end else if (core_clear) begin
         ptr_r <= QPFES_RESET_VECTOR;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // The address sent to program memory is the pointer before its phase one
   // step, held for the whole fetch cycle.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         addr_r <= QPFES_RESET_VECTOR;
      end else if (core_clear) begin
         addr_r <= QPFES_RESET_VECTOR;
      end else if (ph_one) begin
         addr_r <= ptr_r;
      end
   end

   // ---------------------------------------------------------------
   // Fetch stage
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fetch_r <= QPFES_NOP_WORD;
         fetch_valid_r <= 1'b0;
      end else if (core_clear) begin
         fetch_r <= QPFES_NOP_WORD;
         fetch_valid_r <= 1'b0;
      end else if (ph_four) begin
         fetch_r <= prog_rdata;
         // A word fetched while the redirect is decided is stale. Only that one
         // word is dropped, so a pointer change costs exactly one extra cycle.
         fetch_valid_r <= !redirect_now;
      end
   end

   // ---------------------------------------------------------------
   // Execute stage
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ir_r <= QPFES_NOP_WORD;
         exec_valid_r <= 1'b0;
      end else if (core_clear) begin
         ir_r <= QPFES_NOP_WORD;
         exec_valid_r <= 1'b0;
      end else if (ph_one) begin
         ir_r <= fetch_valid_r ? fetch_r : QPFES_NOP_WORD;
         exec_valid_r <= fetch_valid_r;
      end
   end

   // Interrupt entry is acknowledged in the cycle that fetches the vector.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_ack_r <= 1'b0;
      end else if (core_clear) begin
         irq_ack_r <= 1'b0;
      end else begin
         irq_ack_r <= redirect_now && irq_req;
      end
   end

   // Data strobes are registered one phase ahead so they align with the
   // phase they serve. The read strobe looks at the fetch flag, because the
   // instruction register is loaded from it on the same edge.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_r <= 1'b0;
      end else if (core_clear) begin
         rd_r <= 1'b0;
      end else begin
         rd_r <= ph_one && fetch_valid_r;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= 1'b0;
      end else if (core_clear) begin
         wr_r <= 1'b0;
      end else begin
         wr_r <= phase_three && exec_valid_r;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         done_r <= 1'b0;
      end else if (core_clear) begin
         done_r <= 1'b0;
      end else begin
         done_r <= ph_four && exec_valid_r;
      end
   end

   assign instruction_pointer = ptr_r;
   assign prog_addr = addr_r;
   assign instruction_register = ir_r;
   assign exec_valid = exec_valid_r;
   assign data_rd_en = rd_r;
   assign data_wr_en = wr_r;
   assign exec_done = done_r;
   assign irq_ack = irq_ack_r;
   assign phase_one = ph_one;
   assign phase_two = ph_two;
   assign phase_four = ph_four;
endmodule : qpfes_sequencer

// file: verilog/qpfes_pkg.sv
// Shared constants and types of the four-phase fetch/execute sequencer.
package qpfes_pkg;
   // ---------------------------------------------------------------
   // Widths and vectors
   // ---------------------------------------------------------------
   localparam int QPFES_PTR_W = 13;
   localparam int QPFES_WORD_W = 14;
   localparam int QPFES_DATA_W = 8;
   localparam logic [12:0] QPFES_RESET_VECTOR = 13'h0000;
   localparam logic [12:0] QPFES_IRQ_VECTOR = 13'h0004;
   localparam logic [12:0] QPFES_PTR_STEP = 13'h0001;
   // Default implemented space: 2K words; the mask keeps fetches inside it.
   localparam logic [12:0] QPFES_IMPL_MASK = 13'h07FF;
   // Word executed when the execute stage is empty or flushed.
   localparam logic [13:0] QPFES_NOP_WORD = 14'h0000;
   localparam logic [1:0] QPFES_PHASE_FIRST = 2'h0;
   localparam logic [1:0] QPFES_PHASE_LAST = 2'h3;
   localparam logic [1:0] QPFES_PHASE_STEP = 2'h1;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      QPFES_PH_ONE,
      QPFES_PH_TWO,
      QPFES_PH_THREE,
      QPFES_PH_FOUR
   } qpfes_phase_t;
endpackage : qpfes_pkg

// file: verilog/qpfes_phase_gen.sv
// Divide-by-four phase generator producing four one-hot phase enables.
`timescale 1ns/100ps
module qpfes_phase_gen
   import qpfes_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic osc_mode_rc,
   output logic phase_one,
   output logic phase_two,
   output logic phase_three,
   output logic phase_four,
   output logic cycle_rate_output_pin
);
   qpfes_phase_t phase_r;
   logic clkout_r;

   // ---------------------------------------------------------------
   // Phase counter
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= QPFES_PH_ONE;
      end else begin
         case (phase_r)
            QPFES_PH_ONE: phase_r <= QPFES_PH_TWO;
            QPFES_PH_TWO: phase_r <= QPFES_PH_THREE;
            QPFES_PH_THREE: phase_r <= QPFES_PH_FOUR;
            default: phase_r <= QPFES_PH_ONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Cycle-rate pin
   // ---------------------------------------------------------------
   // High for phases one and two, low for three and four: a square wave at
   // a quarter of the input rate. Held low outside RC mode, where the pin
   // belongs to the crystal.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clkout_r <= 1'b0;
      end else begin
         clkout_r <= osc_mode_rc && (phase_r == QPFES_PH_FOUR || phase_r == QPFES_PH_ONE);
      end
   end

   // Decoding from one counter keeps the phases non-overlapping.
   assign phase_one = (phase_r == QPFES_PH_ONE);
   assign phase_two = (phase_r == QPFES_PH_TWO);
   assign phase_three = (phase_r == QPFES_PH_THREE);
   assign phase_four = (phase_r == QPFES_PH_FOUR);
   assign cycle_rate_output_pin = clkout_r;
endmodule : qpfes_phase_gen

// file: bench/qpfes_properties.sv
// Port-level concurrent checks of the four-phase fetch/execute sequencer.
`timescale 1ns/100ps
module qpfes_properties
   import qpfes_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic master_clear_n,
   input wire logic osc_mode_rc,
   input wire logic [12:0] impl_mask,
   input wire logic branch_req,
   input wire logic [12:0] branch_target,
   input wire logic irq_req,
   input wire logic [12:0] instruction_pointer,
   input wire logic [12:0] prog_addr,
   input wire logic [13:0] instruction_register,
   input wire logic exec_valid,
   input wire logic data_rd_en,
   input wire logic data_wr_en,
   input wire logic phase_one,
   input wire logic phase_two,
   input wire logic phase_three,
   input wire logic phase_four,
   input wire logic cycle_rate_output_pin
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn || !master_clear_n);
   property p_rot;
      phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
   endproperty
   a_rot: assert property (p_rot) else $error("phase order broken");
   property p_ptr;
      phase_one |=> instruction_pointer == (($past(instruction_pointer) + 13'h0001) & impl_mask);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer step wrong");
   property p_addr;
      phase_one |=> prog_addr == $past(instruction_pointer);
   endproperty
   a_addr: assert property (p_addr) else $error("fetch address wrong");
   property p_ir;
      !phase_one |=> $stable(instruction_register);
   endproperty
   a_ir: assert property (p_ir) else $error("instruction moved outside phase one");
   property p_rd;
      data_rd_en == (phase_two && exec_valid);
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe misplaced");
   property p_wr;
      data_wr_en == (phase_four && exec_valid);
   endproperty
   a_wr: assert property (p_wr) else $error("write strobe misplaced");
   // The flushed word must show as an empty execute right after the redirect,
   // and the target must execute in the cycle after that.
   property p_br;
      phase_four && exec_valid && branch_req && !irq_req |=>
         instruction_pointer == ($past(branch_target) & impl_mask) ##1
         (!exec_valid && instruction_register == 14'h0000) ##4 exec_valid;
   endproperty
   a_br: assert property (p_br) else $error("branch redirect or flush wrong");
   // The pin is registered, so the edge right after a clear is skipped.
   property p_pin;
      $stable(osc_mode_rc) && $past(resetn) && $past(master_clear_n) |->
         cycle_rate_output_pin == (osc_mode_rc && (phase_one || phase_two));
   endproperty
   a_pin: assert property (p_pin) else $error("cycle rate pin wrong");
   c_br: cover property (phase_four && exec_valid && branch_req);
   c_rd: cover property (data_rd_en);
   c_pin: cover property (cycle_rate_output_pin);
endmodule : qpfes_properties

// file: bench/qpfes_prog_mem.sv
// Program memory model answering each fetch address with a tagged word.
`timescale 1ns/100ps
module qpfes_prog_mem (
   input wire logic [12:0] prog_addr,
   output logic [13:0] prog_rdata
);
   assign prog_rdata = {1'b1, prog_addr};
endmodule : qpfes_prog_mem

// file: bench/tb.sv
// Self-checking bench of the four-phase fetch/execute sequencer.
`timescale 1ns/100ps
module tb;
   import qpfes_pkg::*;
   logic sys_clk = 0, resetn = 0, master_clear_n = 1, osc_mode_rc = 1, branch_req = 0;
   logic irq_req = 0, exec_valid, irq_ack, phase_one, phase_two, phase_three, phase_four;
   logic pin, data_rd_en, data_wr_en, exec_done;
   logic [12:0] impl_mask = 13'h07FF, branch_target = 13'h0000, ip, pa, pc_e;
   logic [13:0] prog_rdata, ir;
   int err_total = 0, total_checks = 0, rd_n = 0, wr_n = 0, ack_n = 0, done_n = 0;
   qpfes_sequencer DUT (.sys_clk, .resetn, .master_clear_n, .osc_mode_rc, .impl_mask,
      .prog_rdata, .branch_req, .branch_target, .irq_req, .instruction_pointer(ip),
      .prog_addr(pa), .instruction_register(ir), .exec_valid, .data_rd_en, .data_wr_en,
      .exec_done, .irq_ack, .phase_one, .phase_two, .phase_three, .phase_four,
      .cycle_rate_output_pin(pin));
   qpfes_prog_mem mem (.prog_addr(pa), .prog_rdata);
   initial forever #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      rd_n <= rd_n + int'(data_rd_en === 1'b1);
      wr_n <= wr_n + int'(data_wr_en === 1'b1);
      ack_n <= ack_n + int'(irq_ack === 1'b1);
      done_n <= done_n + int'(exec_done === 1'b1);
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // Bounded wait for one phase; a stuck divider ends the run here.
   task automatic to_ph(logic [3:0] p);
      for (int i = 0; i < 9; i++) begin
         @(posedge sys_clk);
         #1;
         if ({phase_one, phase_two, phase_three, phase_four} === p) return;
      end
      chk("phase wait", 0, 1);
      wrap_up();
   endtask : to_ph
   task automatic nxt(logic [13:0] e, logic v);
      to_ph(4'h4);
      chk("instruction_register", ir, e);
      chk("exec_valid", exec_valid, v);
      chk("cycle_rate_output_pin", pin, osc_mode_rc);
   endtask : nxt
   task automatic adv;
      nxt({1'b1, pc_e}, 1);
      chk("prog_addr", pa, (pc_e + 13'h0001) & impl_mask);
      chk("instruction_pointer", ip, (pc_e + 13'h0002) & impl_mask);
      pc_e = (pc_e + 13'h0001) & impl_mask;
   endtask : adv
   task automatic t_start;
      chk("phase_one", phase_one, 1);
      chk("instruction_register", ir, 0);
      pc_e = 13'h0000;
      nxt(14'h0000, 0);
      adv();
      $display("t_start done");
   endtask : t_start
   task automatic t_seq;
      int r, w, d;
      r = rd_n;
      w = wr_n;
      d = done_n;
      repeat (4) adv();
      chk("reads", rd_n - r, 4);
      chk("writes", wr_n - w, 4);
      chk("exec_done", done_n - d, 4);
      $display("t_seq done");
   endtask : t_seq
   task automatic t_br(logic irq);
      int a;
      a = ack_n;
      to_ph(4'h2);
      @(posedge sys_clk);
      branch_req <= 1;
      irq_req <= irq;
      branch_target <= 13'h1FFF;
      @(posedge sys_clk);
      branch_req <= 0;
      irq_req <= 0;
      pc_e = irq ? 13'h0004 : 13'h1FFF & impl_mask;
      nxt(14'h0000, 0);
      adv();
      adv();
      chk("irq_ack", ack_n - a, irq);
      $display("t_br done");
   endtask : t_br
   // The mask only changes under clear, so no fetch sees a half-applied space.
   task automatic t_clr;
      to_ph(4'h2);
      @(posedge sys_clk);
      master_clear_n <= 0;
      impl_mask <= 13'h03FF;
      to_ph(4'h8);
      chk("exec_valid", exec_valid, 0);
      @(posedge sys_clk);
      master_clear_n <= 1;
      #1;
      t_start();
      $display("t_clr done");
   endtask : t_clr
   task automatic t_pin;
      @(posedge sys_clk);
      osc_mode_rc <= 0;
      repeat (2) adv();
      $display("t_pin done");
   endtask : t_pin
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1;
      #1;
      t_start();
      t_seq();
      t_br(0);
      t_br(1);
      t_clr();
      t_br(0);
      t_pin();
      wrap_up();
   end
endmodule : tb
bind qpfes_sequencer qpfes_properties chk_i (
   .sys_clk(sys_clk),
   .resetn(resetn),
   .master_clear_n(master_clear_n),
   .osc_mode_rc(osc_mode_rc),
   .impl_mask(impl_mask),
   .branch_req(branch_req),
   .branch_target(branch_target),
   .irq_req(irq_req),
   .instruction_pointer(instruction_pointer),
   .prog_addr(prog_addr),
   .instruction_register(instruction_register),
   .exec_valid(exec_valid),
   .data_rd_en(data_rd_en),
   .data_wr_en(data_wr_en),
   .phase_one(phase_one),
   .phase_two(phase_two),
   .phase_three(phase_three),
   .phase_four(phase_four),
   .cycle_rate_output_pin(cycle_rate_output_pin)
);
